// >>> rtl/pio_device.sv
// device end: direct pin objects and slave A parallel port
//
// Local design decisions: the address map and the strobed register port.
`default_nettype none
module pio_device
    import pio_pkg::*;
#(
    parameter int WDOG_CYCLES = pio_pkg::WDOG_CYC
) (
    // clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_ce,
    // register port
    input  wire logic [pio_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [pio_pkg::REG_W-1:0]  i_wdata,
    input  wire logic                       i_we,
    input  wire logic                       i_re,
    output logic      [pio_pkg::REG_W-1:0]  o_rdata,
    // application hold during a transfer
    output logic                            o_busy,
    // pins
    pio_if.device                           bus
);
    import pio_pkg::*;

    localparam int WD_W = $clog2(WDOG_CYCLES + 1);

    typedef struct packed {
        logic                tick;
        logic [NPINS-1:0]    s1;
        logic [NPINS-1:0]    s2;
        logic [LVL_PINS-1:0] s3;
        logic                par_en;
        role_t               role;
        logic [NPINS-1:0]    dir;
        logic [NPINS-1:0]    outv;
        logic [2:0]          nib_lsb;
        logic [LVL_PINS-1:0] lvl_en;
        logic [LVL_PINS-1:0] lvl;
        pst_t                pst;
        sync_t               stage;
        logic                rd_op;
        logic [DATA_W-1:0]   rx;
        logic [DATA_W-1:0]   tx;
        logic [DATA_W-1:0]   dout;
        logic                rx_full;
        logic                tx_full;
        logic                tout;
        logic [CNT_W-1:0]    remain;
        logic [PACE_W-1:0]   pace;
        logic [WD_W-1:0]     wd;
        logic [REG_W-1:0]    rdata;
        logic [NPINS-1:0]    pin_o;
        logic [NPINS-1:0]    pin_oe;
        logic                busy;
    } dev_state_t;

    dev_state_t s;
    dev_state_t next_s;

    logic [LVL_PINS-1:0] fall;
    logic                active;
    logic                ready;
    logic                cs_low;
    logic                rw_rd;
    logic [DATA_W-1:0]   byte_in;

    always_comb begin
        next_s  = s;
        // falling edge seen by half-rate sampler
        fall    = s.tick ? (s.s3 & ~s.s2[LVL_PINS-1:0] & s.lvl_en
                            & ~s.dir[LVL_PINS-1:0]) : '0;
        // only slave A role runs the port
        active  = s.par_en && (s.role == ROLE_SLAVE_A);
        cs_low  = ~s.s2[PIN_SEL];
        rw_rd   = s.s2[PIN_RW];
        byte_in = s.s2[DATA_W-1:0];
        ready   = (s.stage != ST_SYNCED) || (s.remain != '0 && !s.rx_full);
        if (i_ce) begin
            // two flops, sampled every second clock
            next_s.tick = ~s.tick;
            if (s.tick) begin
                next_s.s1 = bus.pin;
                next_s.s2 = s.s1;
                next_s.s3 = s.s2[LVL_PINS-1:0];
            end
            next_s.rdata = '0;
            if (i_we) begin
                case (i_addr)
                    REG_CTRL: begin
                        next_s.par_en = i_wdata[CTRL_PAR_BIT];
                        next_s.role   = role_t'(i_wdata[CTRL_ROLE_LSB +: 2]);
                    end
                    REG_DIR:     next_s.dir = i_wdata[NPINS-1:0];
                    REG_OUT:     next_s.outv = i_wdata[NPINS-1:0];
                    // byte write, bit 0 to pin 0
                    REG_BYTE:    next_s.outv[DATA_W-1:0] = i_wdata[DATA_W-1:0];
                    REG_NIB_CFG: begin
                        if (i_wdata[2:0] <= NIB_LSB_MAX) begin
                            next_s.nib_lsb = i_wdata[2:0];
                        end
                    end
                    REG_NIB: begin
                        next_s.outv = (s.outv & ~(NIB_MASK << s.nib_lsb))
                            | (NPINS'(i_wdata[NIB_W-1:0]) << s.nib_lsb);
                    end
                    REG_LVL_EN:  next_s.lvl_en = i_wdata[LVL_PINS-1:0];
                    REG_PTX: begin
                        next_s.tx      = i_wdata[DATA_W-1:0];
                        next_s.tx_full = 1'b1;
                    end
                    REG_PLEN:    next_s.remain = i_wdata[CNT_W-1:0];
                    default: ;
                endcase
            end
            if (i_re) begin
                case (i_addr)
                    REG_CTRL: begin
                        next_s.rdata[CTRL_PAR_BIT] = s.par_en;
                        next_s.rdata[CTRL_ROLE_LSB +: 2] = s.role;
                    end
                    REG_DIR:     next_s.rdata[NPINS-1:0] = s.dir;
                    REG_OUT:     next_s.rdata[NPINS-1:0] = s.outv;
                    // plain inputs show the synced level
                    REG_IN:      next_s.rdata[NPINS-1:0] = s.s2;
                    REG_BYTE:    next_s.rdata[DATA_W-1:0] = s.s2[DATA_W-1:0];
                    REG_NIB_CFG: next_s.rdata[2:0] = s.nib_lsb;
                    REG_NIB: begin
                        next_s.rdata[NIB_W-1:0] = NIB_W'(s.s2 >> s.nib_lsb);
                    end
                    REG_LVL_EN:  next_s.rdata[LVL_PINS-1:0] = s.lvl_en;
                    REG_LVL: begin
                        next_s.rdata[LVL_PINS-1:0] = s.lvl;
                        next_s.lvl = '0;
                    end
                    REG_PSTAT: begin
                        next_s.rdata[0] = (s.stage == ST_SYNCED);
                        next_s.rdata[1] = s.busy;
                        next_s.rdata[2] = s.rx_full;
                        next_s.rdata[3] = s.tx_full;
                        next_s.rdata[4] = s.tout;
                        next_s.tout     = 1'b0;
                    end
                    REG_PRX: begin
                        next_s.rdata[DATA_W-1:0] = s.rx;
                        next_s.rx_full = 1'b0;
                    end
                    REG_PLEN:    next_s.rdata[CNT_W-1:0] = s.remain;
                    default: ;
                endcase
            end
            // a new edge beats the clear
            next_s.lvl = next_s.lvl | fall;
            // resync watchdog; set wins over the status read
            if (active && s.stage == ST_WAIT && !s.tout) begin
                next_s.wd = WD_W'(s.wd + 1'b1);
                if (s.wd == WD_W'(WDOG_CYCLES - 1)) begin
                    next_s.tout = 1'b1;
                end
            end
            // pacing counter from select to ready
            if (s.pst != P_IDLE && s.pace != PACE_W'(PACE_CYC - 1)) begin
                next_s.pace = PACE_W'(s.pace + 1'b1);
            end
            case (s.pst)
                P_IDLE: begin
                    // a select while not ready is ignored
                    if (active && ready && cs_low) begin
                        next_s.pst   = P_SEL;
                        next_s.pace  = '0;
                        next_s.rd_op = rw_rd;
                        // master write is a slave read
                        if (!rw_rd) begin
                            // only the resync byte leaves wait
                            if (s.stage == ST_WAIT
                                && byte_in == RESYNC_COMMAND_BYTE) begin
                                next_s.stage = ST_ACK;
                            end else if (s.stage == ST_SYNCED) begin
                                next_s.rx      = byte_in;
                                next_s.rx_full = 1'b1;
                                next_s.remain  = CNT_W'(s.remain - 1'b1);
                            end
                        end else if (s.stage == ST_ACK) begin
                            next_s.dout  = RESYNC_ACK_BYTE;
                            next_s.stage = ST_SYNCED;
                        end else begin
                            next_s.dout = s.tx;
                            if (s.stage == ST_SYNCED) begin
                                next_s.tx_full = 1'b0;
                                next_s.remain  = CNT_W'(s.remain - 1'b1);
                            end
                        end
                    end
                end
                P_SEL: begin
                    if (!cs_low) begin
                        next_s.pst = P_DONE;
                    end
                end
                P_DONE: begin
                    // never faster than the byte period
                    if (s.pace == PACE_W'(PACE_CYC - 1) && ready) begin
                        next_s.pst = P_IDLE;
                    end
                end
                default: next_s.pst = P_IDLE;
            endcase
            if (!active) begin
                next_s.pst = P_IDLE;
            end
            // pins follow next state so every pin is a flop output
            next_s.pin_o  = '0;
            next_s.pin_oe = '0;
            if (active) begin
                // slave always drives the handshake line
                next_s.pin_oe[PIN_HS] = 1'b1;
                next_s.pin_o[PIN_HS]  = (next_s.pst != P_IDLE) || !ready;
                // data driven only while selected for a read
                if (next_s.pst == P_SEL && next_s.rd_op) begin
                    next_s.pin_oe[DATA_W-1:0] = '1;
                    next_s.pin_o[DATA_W-1:0]  = next_s.dout;
                end
            end else if (!s.par_en) begin
                // parallel mode takes all pins away from bit use
                next_s.pin_o  = next_s.outv;
                next_s.pin_oe = next_s.dir;
            end
            next_s.busy = s.par_en && (next_s.remain != '0
                          || next_s.stage != ST_SYNCED);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_rdata    = s.rdata;
    assign o_busy     = s.busy;
    assign bus.dev_o  = s.pin_o;
    assign bus.dev_oe = s.pin_oe;
endmodule // pio_device
`default_nettype wire

// >>> rtl/pio_if.sv
// eleven shared pins between the device end and the far end
`default_nettype none
interface pio_if;
    logic [pio_pkg::NPINS-1:0] dev_o;
    logic [pio_pkg::NPINS-1:0] dev_oe;
    logic [pio_pkg::NPINS-1:0] far_o;
    logic [pio_pkg::NPINS-1:0] far_oe;
    logic [pio_pkg::NPINS-1:0] pin;
    // released pins float high through pull-ups
    assign pin = (dev_o & dev_oe) | (far_o & far_oe) | ~(dev_oe | far_oe);
    modport device (output dev_o, output dev_oe, input pin);
    modport far (output far_o, output far_oe, input pin);
endinterface
`default_nettype wire

// >>> rtl/pio_master.sv
// far end: parallel port master driving select and read/write
`default_nettype none
module pio_master
    import pio_pkg::*;
(
    // clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_ce,
    // register port
    input  wire logic [pio_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [pio_pkg::REG_W-1:0]  i_wdata,
    input  wire logic                       i_we,
    input  wire logic                       i_re,
    output logic      [pio_pkg::REG_W-1:0]  o_rdata,
    // byte or resync in progress
    output logic                            o_busy,
    // pins
    pio_if.far                              bus
);
    import pio_pkg::*;

    typedef enum logic [1:0] {
        SQ_RESYNC = 2'h0, SQ_ACK = 2'h1, SQ_DONE = 2'h3
    } seq_t;

    typedef struct packed {
        logic [NPINS-1:0]  s1;
        logic [NPINS-1:0]  s2;
        mst_t              mst;
        seq_t              seq;
        logic              op_rd;
        logic [DATA_W-1:0] txb;
        logic [DATA_W-1:0] rxb;
        logic              rx_valid;
        logic              ack_err;
        logic [CNT_W-1:0]  remain;
        logic [CNT_W-1:0]  cnt;
        logic [REG_W-1:0]  rdata;
        logic [NPINS-1:0]  pin_o;
        logic [NPINS-1:0]  pin_oe;
        logic              busy;
    } mst_state_t;

    mst_state_t s;
    mst_state_t next_s;
    logic       hs;
    logic       cmd_ok;

    always_comb begin
        next_s = s;
        hs     = s.s2[PIN_HS];
        // commands refused once the byte budget is spent
        cmd_ok = s.seq == SQ_DONE && s.mst == M_IDLE && s.remain != '0;
        if (i_ce) begin
            next_s.s1    = bus.pin;
            next_s.s2    = s.s1;
            next_s.rdata = '0;
            if (i_re) begin
                case (i_addr)
                    H_REG_STAT: begin
                        next_s.rdata[0] = (s.seq == SQ_DONE);
                        next_s.rdata[1] = s.busy;
                        next_s.rdata[2] = s.rx_valid;
                        next_s.rdata[3] = s.ack_err;
                    end
                    H_REG_LEN: next_s.rdata[CNT_W-1:0] = s.remain;
                    H_REG_RX: begin
                        next_s.rdata[DATA_W-1:0] = s.rxb;
                        next_s.rx_valid = 1'b0;
                    end
                    default: ;
                endcase
            end
            if (i_we && i_addr == H_REG_LEN) begin
                next_s.remain = i_wdata[CNT_W-1:0];
            end
            case (s.mst)
                M_INIT: begin
                    // wait for handshake low, then resync
                    // resync sent at once, inside the watchdog
                    if (!hs) begin
                        next_s.mst   = M_SETUP;
                        next_s.op_rd = 1'b0;
                        next_s.txb   = RESYNC_COMMAND_BYTE;
                        next_s.cnt   = '0;
                    end
                end
                M_IDLE: begin
                    if (i_we && cmd_ok
                        && (i_addr == H_REG_TX || i_addr == H_REG_RD)) begin
                        next_s.mst    = M_SETUP;
                        next_s.cnt    = '0;
                        // read and write named from this side
                        next_s.op_rd  = (i_addr == H_REG_RD);
                        next_s.txb    = i_wdata[DATA_W-1:0];
                        next_s.remain = CNT_W'(s.remain - 1'b1);
                    end
                end
                M_SETUP: begin
                    next_s.cnt = CNT_W'(s.cnt + 1'b1);
                    if (s.cnt == CNT_W'(SETUP_CYC - 1)) begin
                        next_s.mst = M_STROBE;
                        next_s.cnt = '0;
                    end
                end
                M_STROBE: begin
                    if (s.cnt != CNT_W'(CS_PW_CYC - 1)) begin
                        next_s.cnt = CNT_W'(s.cnt + 1'b1);
                    end else if (hs) begin
                        next_s.mst = M_RELEASE;
                        if (s.op_rd) begin
                            next_s.rxb = s.s2[DATA_W-1:0];
                        end
                    end
                end
                M_RELEASE: begin
                    next_s.mst = M_WAIT;
                    if (s.op_rd && s.seq == SQ_DONE) begin
                        next_s.rx_valid = 1'b1;
                    end
                end
                M_WAIT: begin
                    // next byte only after handshake low
                    if (!hs) begin
                        next_s.mst = M_IDLE;
                        if (s.seq == SQ_RESYNC) begin
                            next_s.seq   = SQ_ACK;
                            next_s.mst   = M_SETUP;
                            next_s.op_rd = 1'b1;
                            next_s.cnt   = '0;
                        end else if (s.seq == SQ_ACK) begin
                            if (s.rxb == RESYNC_ACK_BYTE) begin
                                next_s.seq = SQ_DONE;
                            end else begin
                                next_s.ack_err = 1'b1;
                                next_s.seq     = SQ_RESYNC;
                                next_s.mst     = M_INIT;
                            end
                        end
                    end
                end
                default: next_s.mst = M_INIT;
            endcase
            next_s.pin_o  = '0;
            next_s.pin_oe = '0;
            next_s.pin_oe[PIN_SEL] = 1'b1;
            next_s.pin_o[PIN_SEL]  = (next_s.mst != M_STROBE);
            next_s.pin_oe[PIN_RW]  = 1'b1;
            next_s.pin_o[PIN_RW]   = next_s.op_rd;
            // write data held until handshake low
            // released for reads before select falls
            if (!next_s.op_rd && next_s.mst != M_IDLE
                && next_s.mst != M_INIT) begin
                next_s.pin_oe[DATA_W-1:0] = '1;
                next_s.pin_o[DATA_W-1:0]  = next_s.txb;
            end
            next_s.busy = (next_s.mst != M_IDLE) || (next_s.seq != SQ_DONE);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            s     <= '0;
            s.mst <= M_INIT;
            // pins idle high; a zero here would fake a ready handshake
            s.s1  <= '1;
            s.s2  <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign o_rdata    = s.rdata;
    assign o_busy     = s.busy;
    assign bus.far_o  = s.pin_o;
    assign bus.far_oe = s.pin_oe;
endmodule // pio_master
`default_nettype wire

// >>> rtl/pio_pkg.sv
// shared constants and types for the direct pin and parallel port ends
`default_nettype none
package pio_pkg;
    // clock and widths
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_MHZ       = 20;
    localparam int REF_CLK_MHZ   = 10;
    localparam int NPINS         = 11;
    localparam int DATA_W        = 8;
    localparam int LVL_PINS      = 8;
    localparam int NIB_W         = 4;
    localparam int REG_W         = 16;
    localparam int ADDR_W        = 4;
    localparam int CNT_W         = 8;
    localparam logic [2:0] NIB_LSB_MAX = 3'h4;
    localparam logic [NPINS-1:0] NIB_MASK = 11'h00f;
    // control pin positions in parallel mode
    localparam int PIN_SEL = 8;
    localparam int PIN_RW  = 9;
    localparam int PIN_HS  = 10;
    // handshake characters
    localparam logic [DATA_W-1:0] RESYNC_COMMAND_BYTE = 8'h5a;
    localparam logic [DATA_W-1:0] RESYNC_ACK_BYTE     = 8'h07;
    // timing
    localparam int BYTE_NS    = 2400;
    localparam int PACE_CYC   = BYTE_NS * REF_CLK_MHZ / CLK_MHZ / CLK_PERIOD_NS;
    localparam int PACE_W     = $clog2(PACE_CYC + 1);
    localparam int WDOG_NS    = 840_000_000;
    localparam int WDOG_CYC   = WDOG_NS / CLK_PERIOD_NS;
    localparam int SETUP_NS   = 150;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_PW_NS   = 150;
    localparam int CS_PW_CYC  = (CS_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // device register map
    localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
    localparam logic [ADDR_W-1:0] REG_DIR     = 4'h1;
    localparam logic [ADDR_W-1:0] REG_OUT     = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IN      = 4'h3;
    localparam logic [ADDR_W-1:0] REG_BYTE    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_NIB_CFG = 4'h5;
    localparam logic [ADDR_W-1:0] REG_NIB     = 4'h6;
    localparam logic [ADDR_W-1:0] REG_LVL_EN  = 4'h7;
    localparam logic [ADDR_W-1:0] REG_LVL     = 4'h8;
    localparam logic [ADDR_W-1:0] REG_PSTAT   = 4'h9;
    localparam logic [ADDR_W-1:0] REG_PRX     = 4'ha;
    localparam logic [ADDR_W-1:0] REG_PTX     = 4'hb;
    localparam logic [ADDR_W-1:0] REG_PLEN    = 4'hc;
    localparam int CTRL_PAR_BIT  = 0;
    localparam int CTRL_ROLE_LSB = 1;
    // host register map
    localparam logic [ADDR_W-1:0] H_REG_STAT = 4'h0;
    localparam logic [ADDR_W-1:0] H_REG_LEN  = 4'h1;
    localparam logic [ADDR_W-1:0] H_REG_TX   = 4'h2;
    localparam logic [ADDR_W-1:0] H_REG_RD   = 4'h3;
    localparam logic [ADDR_W-1:0] H_REG_RX   = 4'h4;
    typedef enum logic [1:0] {
        ROLE_MASTER = 2'h0, ROLE_SLAVE_A = 2'h1, ROLE_SLAVE_B = 2'h2
    } role_t;
    typedef enum logic [1:0] {
        ST_WAIT = 2'h0, ST_ACK = 2'h1, ST_SYNCED = 2'h3
    } sync_t;
    typedef enum logic [1:0] {
        P_IDLE = 2'h0, P_SEL = 2'h1, P_DONE = 2'h3
    } pst_t;
    typedef enum logic [2:0] {
        M_IDLE = 3'h0, M_SETUP = 3'h1, M_STROBE = 3'h3,
        M_RELEASE = 3'h2, M_WAIT = 3'h6, M_INIT = 3'h4
    } mst_t;
endpackage
`default_nettype wire

// >>> sim/pio_properties.sv
// concurrent checks on the pins shared by the two ends
`default_nettype none
module pio_properties
    import pio_pkg::*;
(
    // clock and reset
    input wire logic             i_mclk,
    input wire logic             i_sys_rst,
    // shared pins
    input wire logic [NPINS-1:0] dev_oe,
    input wire logic [NPINS-1:0] far_o,
    input wire logic [NPINS-1:0] far_oe,
    input wire logic [NPINS-1:0] pin
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // saturates so a long idle high never wraps to a short count
    logic [5:0] hs_hi;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !pin[PIN_HS]) hs_hi <= 6'h00;
        else if (hs_hi != 6'h3f) hs_hi <= hs_hi + 6'h01;
    end
    sequence s_sel_held; !pin[PIN_SEL] [*3]; endsequence
    sequence s_sel_back; ##[1:12] pin[PIN_SEL]; endsequence
    sequence s_hs_up; $rose(pin[PIN_HS]) && dev_oe[PIN_HS]; endsequence
    chk_no_contention: assert property (!(|(dev_oe[7:0] & far_oe[7:0])))
        else $error("data lines driven by both ends");
    chk_far_no_hs: assert property (!far_oe[PIN_HS])
        else $error("master drives handshake");
    chk_sel_width: assert property ($fell(pin[PIN_SEL]) |-> s_sel_held)
        else $error("select pulse too short");
    chk_sel_ready: assert property ($fell(pin[PIN_SEL]) |-> !pin[PIN_HS])
        else $error("select while slave busy");
    chk_wdata_held: assert property (far_oe[0] && $past(far_oe[0])
        |-> $stable(far_o[7:0])) else $error("write data moved");
    chk_wdata_kept: assert property ($fell(far_oe[0]) |-> !pin[PIN_HS])
        else $error("write data dropped early");
    chk_hs_selected: assert property (s_hs_up |-> !pin[PIN_SEL])
        else $error("handshake rose unselected");
    chk_sel_release: assert property (s_hs_up |-> s_sel_back)
        else $error("select not released");
    chk_hs_pace: assert property ($fell(pin[PIN_HS])
        |-> pin[PIN_SEL] && hs_hi >= 6'(PACE_CYC)) else $error("byte too fast");
endmodule // pio_properties
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench joining the device end and the master end
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pio_pkg::*;
    logic              i_mclk = 1'b0;
    logic              i_sys_rst = 1'b1;
    logic [ADDR_W-1:0] addr [2];
    logic [REG_W-1:0]  wdata [2];
    logic [REG_W-1:0]  rdata [2];
    logic              we [2];
    logic              re [2];
    logic              busy [2];
    logic [REG_W-1:0]  v;
    int                n_fail = 0;
    int                n_tests = 0;
    always #25 i_mclk = ~i_mclk;
    pio_if i_pio_if ();
    pio_device #(.WDOG_CYCLES(200)) i_pio_device (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_addr(addr[0]),
        .i_wdata(wdata[0]), .i_we(we[0]), .i_re(re[0]),
        .o_rdata(rdata[0]), .o_busy(busy[0]), .bus(i_pio_if.device));
    pio_master i_pio_master (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_ce(1'b1), .i_addr(addr[1]), .i_wdata(wdata[1]), .i_we(we[1]),
        .i_re(re[1]), .o_rdata(rdata[1]), .o_busy(busy[1]),
        .bus(i_pio_if.far));
    pio_properties i_pio_properties (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .dev_oe(i_pio_if.dev_oe),
        .far_o(i_pio_if.far_o), .far_oe(i_pio_if.far_oe),
        .pin(i_pio_if.pin));
    task automatic wr(int m, logic [ADDR_W-1:0] a, logic [REG_W-1:0] d);
        @(posedge i_mclk);
        addr[m] <= a;
        wdata[m] <= d;
        we[m] <= 1'b1;
        @(posedge i_mclk);
        we[m] <= 1'b0;
    endtask
    task automatic rd(int m, logic [ADDR_W-1:0] a);
        @(posedge i_mclk);
        addr[m] <= a;
        re[m] <= 1'b1;
        @(posedge i_mclk);
        re[m] <= 1'b0;
        #1 v = rdata[m];
    endtask
    task automatic chk(string s, logic [REG_W-1:0] e, logic [REG_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rc(int m, logic [ADDR_W-1:0] a, logic [REG_W-1:0] e);
        rd(m, a);
        chk($sformatf("reg %0d.%h", m, a), e, v);
    endtask
    // a lost handshake ends the run here instead of hanging
    task automatic poll(int m, logic [ADDR_W-1:0] a, int b, logic e);
        for (int k = 0; k < 400; k++) begin
            rd(m, a);
            if (v[b] === e) return;
        end
        n_fail++;
        conclude();
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        addr = '{default: '0};
        wdata = '{default: '0};
        we = '{default: 1'b0};
        re = '{default: 1'b0};
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        rc(0, REG_CTRL, 16'h0000); // role off
        wr(0, REG_DIR, 16'h00ff); // outputs
        wr(0, REG_OUT, 16'h00c4); // levels
        repeat (8) @(posedge i_mclk);
        chk("pins", 16'h00c4, 16'(i_pio_if.pin[7:0])); // bit output
        rc(0, REG_IN, 16'h05c4); // current levels
        wr(0, REG_BYTE, 16'h001e); // byte write
        repeat (8) @(posedge i_mclk);
        chk("byte", 16'h001e, 16'(i_pio_if.pin[7:0])); // lsb order
        rc(0, REG_BYTE, 16'h001e); // byte port
        for (int p = 0; p <= 4; p++) begin
            wr(0, REG_NIB_CFG, 16'(p)); // lowest pin
            wr(0, REG_NIB, 16'h000b); // nibble write
            repeat (8) @(posedge i_mclk);
            chk("nib", 16'h000b, 16'(i_pio_if.pin[p+:4])); // lowest pin
            rc(0, REG_NIB, 16'h000b); // nibble port
        end
        wr(0, REG_NIB_CFG, 16'h0005); // out of range
        rc(0, REG_NIB_CFG, 16'h0004); // range limit
        wr(0, REG_DIR, 16'h0000); // all inputs
        repeat (8) @(posedge i_mclk);
        chk("float", 16'h00ff, 16'(i_pio_if.pin[7:0])); // back to input
        rc(0, REG_BYTE, 16'h00ff); // byte input
        rc(0, REG_NIB, 16'h000f); // nibble input
        wr(0, REG_LVL_EN, 16'h00ff); // level detect on
        wr(0, REG_PLEN, 16'h0002); // byte budget
        wr(0, REG_CTRL, 16'h0003); // slave A
        poll(1, H_REG_STAT, 0, 1'b1); // resync sent
        rd(0, REG_PSTAT); // status
        chk("synced", 16'h0001, v & 16'h0001); // resync answered
        chk("timeout", 16'h0000, v & 16'h0010); // resync in time
        // resync traffic left edges behind; this read clears them
        rd(0, REG_LVL); // clear latch
        wr(1, H_REG_LEN, 16'h0002); // byte budget
        wr(1, H_REG_TX, 16'h00c3); // master write
        poll(0, REG_PSTAT, 2, 1'b1); // write lands as read
        rc(0, REG_PRX, 16'h00c3); // data held
        // zero bits of the written byte pull pins 2 to 5 low
        rc(0, REG_LVL, 16'h003c); // falls latched
        rc(0, REG_LVL, 16'h0000); // read cleared
        poll(1, H_REG_STAT, 1, 1'b0); // handshake low
        wr(0, REG_PTX, 16'h0096); // byte to send
        wr(1, H_REG_RD, 16'h0000); // master read
        poll(1, H_REG_STAT, 2, 1'b1); // read direction
        rc(1, H_REG_RX, 16'h0096); // read direction
        // budget spent: handshake stays high, master waits busy
        rc(1, H_REG_STAT, 16'h0003); // no ack error
        rc(0, REG_PLEN, 16'h0000); // count done
        chk("busy", 16'h0000, 16'(busy[0])); // hold released
        conclude();
    end
endmodule // tb_top
`default_nettype wire
